// ### hw/mwj_pkg.sv
// Package of offsets, field positions, reset values and timing counts for the MAC supervision block.
package mwj_pkg;

	localparam logic [7:0] OFS_WAKE_DATA = 8'h70;
	localparam logic [7:0] OFS_WDOG_CTRL = 8'h78;
	localparam logic [7:0] OFS_SEC_STAT  = 8'h80;
	localparam logic [7:0] OFS_SEC_EN    = 8'h84;

	localparam int BIT_REL_SEL = 5;
	localparam int BIT_RXWD_OFF = 4;
	localparam int BIT_JAB_SEL = 2;
	localparam int BIT_NO_HOLD = 1;
	localparam int BIT_JAB_OFF = 0;
	localparam logic [31:0] WDOG_CTRL_MASK = 32'h0000_0037;
	localparam logic [31:0] WDOG_CTRL_RST  = 32'h0000_0000;

	localparam int BIT_ETX   = 31;
	localparam int BIT_ERX   = 30;
	localparam int BIT_XCVR  = 29;
	localparam int BIT_TXDEF = 28;
	localparam int BIT_PAUSE = 26;
	localparam int ERRT_LO   = 23;
	localparam logic [31:0] SEC_EN_MASK = 32'hF400_0000;
	localparam logic [31:0] SEC_EN_RST  = 32'h0000_0000;
	localparam logic [4:0]  SEC_STAT_RST = 5'h04;

	localparam logic [2:0] ERRT_PARITY = 3'h0;
	localparam logic [2:0] ERRT_MABORT = 3'h1;
	localparam logic [2:0] ERRT_TABORT = 3'h2;

	localparam int WAKE_WORDS = 25;
	localparam logic [4:0] WAKE_LAST = 5'h18;

	localparam int CLK_NS = 100;
	localparam int BIT_NS_100 = 10;
	localparam int BIT_NS_10 = 100;
	localparam int RXREL_SHORT_BT = 24;
	localparam int RXREL_LONG_BT = 48;
	localparam int RXWD_BYTES = 2560;
	localparam int JAB_BYTES = 2560;
	localparam int JAB_US_100 = 2600;
	localparam int JAB_US_10 = 26000;
	localparam int HOLD_MS_100 = 42;
	localparam int HOLD_MS_10 = 420;
	localparam int JAB_CYC_100 = (JAB_US_100 * 1000) / CLK_NS;
	localparam int JAB_CYC_10 = (JAB_US_10 * 1000) / CLK_NS;
	localparam int HOLD_CYC_100 = (HOLD_MS_100 * 1000000) / CLK_NS;
	localparam int HOLD_CYC_10 = (HOLD_MS_10 * 1000000) / CLK_NS;

	typedef struct packed {
		logic txEarly;
		logic rxEarly;
		logic txDeferred;
		logic pauseRx;
		logic pauseEnable;
		logic fatalBusError;
		logic [2:0] busErrCode;
		logic [6:0] xcvrIrq;
	} mwj_events_t;

	typedef struct packed {
		logic carrier;
		logic rxByte;
		logic rxBit;
		logic txActive;
		logic txByte;
		logic speed100;
	} mwj_link_t;

	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [31:0] wdata;
	} mwj_csr_t;

endpackage

// ### hw/mwj_tick_count.sv
// Saturating event counter with a programmable limit used by the timers.
module mwj_tick_count (
	input  wire logic        clk,
	input  wire logic        srst,
	input  wire logic        clear,
	input  wire logic        tick,
	input  wire logic [31:0] limit,
	output logic             reached
);
	logic [31:0] count_reg;
	wire         atLimit = (count_reg >= limit);

	always_ff @(posedge clk) begin
		if (srst || clear) begin
			count_reg <= 32'h0000_0000;
		end else if (tick && !atLimit) begin
			count_reg <= count_reg + 32'h0000_0001;
		end
	end

	assign reached = atLimit && !clear;
endmodule

// ### hw/mwj_top.sv
// Watchdog, jabber and secondary status registers of the MAC supervision block.
module mwj_top (
	input  wire logic                 clk,
	input  wire logic                 srst,
	input  wire mwj_pkg::mwj_csr_t    csr,
	input  wire mwj_pkg::mwj_link_t   link,
	input  wire mwj_pkg::mwj_events_t events,
	output logic [31:0]               rdata,
	output logic                      rxWatchdogExpired,
	output logic                      txCutOff,
	output logic [31:0]               wakeWordData,
	output logic [4:0]                wakeWordIndex,
	output logic                      wakeWordValid
);
	parameter int HOLD_CYC_100 = mwj_pkg::HOLD_CYC_100;
	parameter int HOLD_CYC_10  = mwj_pkg::HOLD_CYC_10;
	parameter int JAB_CYC_100  = mwj_pkg::JAB_CYC_100;
	parameter int JAB_CYC_10   = mwj_pkg::JAB_CYC_10;

	typedef enum logic [2:0] {
		MWJ_TX_IDLE = 3'b001,
		MWJ_TX_RUN  = 3'b010,
		MWJ_TX_HOLD = 3'b100
	} mwj_jab_t;

	logic [31:0] wdogCtrl_reg;
	logic [31:0] secEn_reg;
	logic [4:0]  status_reg;
	logic [4:0]  status_next;
	logic [4:0]  wakePtr_reg;
	logic [7:0]  patternOffset_reg [0:4];
	logic [31:0] rdata_reg;
	logic        rxExp_reg;
	logic        txCut_reg;
	logic        wakeValid_reg;
	logic [31:0] wakeData_reg;
	logic [4:0]  wakeIdx_reg;
	logic        inFrame_reg;
	logic        releasing_reg;
	mwj_jab_t    jab_reg;
	mwj_jab_t    jab_next;

	wire wrWake = csr.wr && (csr.addr == mwj_pkg::OFS_WAKE_DATA);
	wire wrCtrl = csr.wr && (csr.addr == mwj_pkg::OFS_WDOG_CTRL);
	wire wrStat = csr.wr && (csr.addr == mwj_pkg::OFS_SEC_STAT);
	wire wrEn   = csr.wr && (csr.addr == mwj_pkg::OFS_SEC_EN);
	wire relLong    = wdogCtrl_reg[mwj_pkg::BIT_REL_SEL];
	wire rxWdOff    = wdogCtrl_reg[mwj_pkg::BIT_RXWD_OFF];
	wire jabByteSel = wdogCtrl_reg[mwj_pkg::BIT_JAB_SEL];
	wire noHoldoff  = wdogCtrl_reg[mwj_pkg::BIT_NO_HOLD];
	wire jabOff     = wdogCtrl_reg[mwj_pkg::BIT_JAB_OFF];
	wire xcvrAny;
	wire [2:0] busErr;
	wire [4:0] setVec;
	wire [4:0] clrVec;
	wire [31:0] statWord;
	wire [31:0] relLimit;
	wire [31:0] jabLimit;
	wire [31:0] holdLimit;
	wire rxBytesHit;
	wire relHit;
	wire jabHit;
	wire holdHit;
	wire txLive;
	wire [2:0] oneCycleAssert;

	assign xcvrAny = |events.xcvrIrq;
	assign busErr = events.fatalBusError ? events.busErrCode : mwj_pkg::ERRT_PARITY;

	assign setVec = {
		events.txEarly && secEn_reg[mwj_pkg::BIT_ETX],
		events.rxEarly && secEn_reg[mwj_pkg::BIT_ERX],
		xcvrAny,
		events.txDeferred,
		events.pauseRx && events.pauseEnable
	};
	assign clrVec = wrStat ? {csr.wdata[mwj_pkg::BIT_ETX], csr.wdata[mwj_pkg::BIT_ERX],
		csr.wdata[mwj_pkg::BIT_XCVR], csr.wdata[mwj_pkg::BIT_TXDEF], csr.wdata[mwj_pkg::BIT_PAUSE]} : 5'h00;

	assign status_next = (status_reg & ~clrVec) | setVec;

	assign statWord = {status_reg[4], status_reg[3], status_reg[2], status_reg[1], 1'b0,
		status_reg[0], busErr, 23'h000000};

	assign relLimit = relLong ? 32'(mwj_pkg::RXREL_LONG_BT) : 32'(mwj_pkg::RXREL_SHORT_BT);
	assign jabLimit = jabByteSel ? 32'(mwj_pkg::JAB_BYTES)
		: (link.speed100 ? 32'(JAB_CYC_100) : 32'(JAB_CYC_10));
	assign holdLimit = link.speed100 ? 32'(HOLD_CYC_100) : 32'(HOLD_CYC_10);

	mwj_tick_count uRxBytes (
		.clk     (clk),
		.srst    (srst),
		.clear   (!inFrame_reg),
		.tick    (link.rxByte),
		.limit   (32'(mwj_pkg::RXWD_BYTES) + 32'h0000_0001),
		.reached (rxBytesHit)
	);

	mwj_tick_count uRelease (
		.clk     (clk),
		.srst    (srst),
		.clear   (!releasing_reg),
		.tick    (link.rxBit),
		.limit   (relLimit),
		.reached (relHit)
	);

	mwj_tick_count uJabber (
		.clk     (clk),
		.srst    (srst),
		.clear   (jab_reg != MWJ_TX_RUN),
		.tick    (jabByteSel ? link.txByte : 1'b1),
		.limit   (jabLimit),
		.reached (jabHit)
	);

	mwj_tick_count uHold (
		.clk     (clk),
		.srst    (srst),
		.clear   (jab_reg != MWJ_TX_HOLD),
		.tick    (1'b1),
		.limit   (holdLimit),
		.reached (holdHit)
	);

	assign txLive = link.txActive && !jabOff;

	always_comb begin
		jab_next = jab_reg;
		case (jab_reg)
			MWJ_TX_IDLE: begin
				if (txLive) begin
					jab_next = MWJ_TX_RUN;
				end
			end
			MWJ_TX_RUN: begin
				if (!txLive) begin
					jab_next = MWJ_TX_IDLE;
				end else if (jabHit) begin
					jab_next = noHoldoff ? MWJ_TX_IDLE : MWJ_TX_HOLD;
				end
			end
			MWJ_TX_HOLD: begin
				if (holdHit || jabOff) begin
					jab_next = MWJ_TX_IDLE;
				end
			end
			default: begin
				jab_next = MWJ_TX_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			wdogCtrl_reg <= mwj_pkg::WDOG_CTRL_RST;
			secEn_reg    <= mwj_pkg::SEC_EN_RST;
			status_reg   <= mwj_pkg::SEC_STAT_RST;
			jab_reg      <= MWJ_TX_IDLE;
		end else begin
			if (wrCtrl) begin
				wdogCtrl_reg <= csr.wdata & mwj_pkg::WDOG_CTRL_MASK;
			end
			if (wrEn) begin
				secEn_reg <= csr.wdata & mwj_pkg::SEC_EN_MASK;
			end
			status_reg <= status_next;
			jab_reg    <= jab_next;
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			inFrame_reg   <= 1'b0;
			releasing_reg <= 1'b0;
			rxExp_reg     <= 1'b0;
		end else begin
			if (link.carrier) begin
				inFrame_reg   <= 1'b1;
				releasing_reg <= 1'b0;
			end else if (inFrame_reg) begin
				inFrame_reg   <= 1'b0;
				releasing_reg <= rxExp_reg;
			end
			if (rxWdOff) begin
				rxExp_reg <= 1'b0;
			end else if (rxBytesHit && link.carrier) begin
				rxExp_reg <= 1'b1;
			end else if (releasing_reg && relHit) begin
				rxExp_reg     <= 1'b0;
				releasing_reg <= 1'b0;
			end else if (!link.carrier && !inFrame_reg && !releasing_reg) begin
				rxExp_reg <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			txCut_reg <= 1'b0;
		end else begin
			txCut_reg <= (jab_next == MWJ_TX_HOLD) || (jab_reg == MWJ_TX_RUN && txLive && jabHit);
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			wakePtr_reg   <= 5'h00;
			wakeValid_reg <= 1'b0;
			wakeData_reg  <= 32'h0000_0000;
			wakeIdx_reg   <= 5'h00;
		end else begin
			wakeValid_reg <= wrWake;
			if (wrWake) begin
				wakeData_reg <= csr.wdata;
				wakeIdx_reg  <= wakePtr_reg;
				wakePtr_reg  <= (wakePtr_reg == mwj_pkg::WAKE_LAST) ? 5'h00 : wakePtr_reg + 5'h01;
			end
		end
	end

	for (genvar p = 0; p < 5; p++) begin : gOffset
		always_ff @(posedge clk) begin
			if (srst) begin
				patternOffset_reg[p] <= 8'h00;
			end else if (wrWake && wakePtr_reg == 5'(5 * p + 4)) begin
				patternOffset_reg[p] <= csr.wdata[7:0];
			end
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			rdata_reg <= 32'h0000_0000;
		end else if (csr.rd) begin
			case (csr.addr)
				mwj_pkg::OFS_WDOG_CTRL: rdata_reg <= wdogCtrl_reg;
				mwj_pkg::OFS_SEC_STAT:  rdata_reg <= statWord;
				mwj_pkg::OFS_SEC_EN:    rdata_reg <= secEn_reg;
				default:                rdata_reg <= 32'h0000_0000;
			endcase
		end
	end

	assign rdata             = rdata_reg;
	assign rxWatchdogExpired = rxExp_reg;
	assign txCutOff          = txCut_reg;
	assign wakeWordData      = wakeData_reg;
	assign wakeWordIndex     = wakeIdx_reg;
	assign wakeWordValid     = wakeValid_reg;

	assign oneCycleAssert = {patternOffset_reg[0][0], patternOffset_reg[4][0], 1'b0};

	a_early_tx_set: assert property (@(posedge clk) disable iff (srst)
		(events.txEarly && secEn_reg[mwj_pkg::BIT_ETX]) |=> status_reg[4])
		else $error("Early transmit flag not set.");

	a_flag_hold: assert property (@(posedge clk) disable iff (srst)
		(status_reg[3] && !(wrStat && csr.wdata[mwj_pkg::BIT_ERX])) |=> status_reg[3])
		else $error("Early receive flag dropped.");

	a_xcvr_or: assert property (@(posedge clk) disable iff (srst)
		(|events.xcvrIrq) |=> status_reg[2])
		else $error("Transceiver flag missing.");

	a_pause_gate: assert property (@(posedge clk) disable iff (srst)
		(!$past(status_reg[0]) && !$past(events.pauseEnable)) |-> !status_reg[0] || $past(srst))
		else $error("Pause flag set while disabled.");

	a_bet_zero: assert property (@(posedge clk) disable iff (srst)
		!events.fatalBusError |-> busErr == 3'h0)
		else $error("Bus error type shown without fatal flag.");

	a_rx_disable: assert property (@(posedge clk) disable iff (srst)
		rxWdOff |=> !rxExp_reg)
		else $error("Watchdog expired while disabled.");

	a_jab_disable: assert property (@(posedge clk) disable iff (srst)
		(jabOff && !txCut_reg) |=> !txCut_reg)
		else $error("Transmit cut while jabber disabled.");

	sequence s_cut;
		jab_reg == MWJ_TX_RUN && txLive && jabHit && noHoldoff;
	endsequence

	a_no_holdoff: assert property (@(posedge clk) disable iff (srst)
		s_cut |=> (jab_reg == MWJ_TX_IDLE) ##1 (!txCut_reg && jab_reg != MWJ_TX_HOLD))
		else $error("Holdoff entered with no-holdoff set.");

	a_reserved_ctrl: assert property (@(posedge clk) disable iff (srst)
		(wdogCtrl_reg & ~mwj_pkg::WDOG_CTRL_MASK) == 32'h0000_0000)
		else $error("Reserved control bit set.");

	a_wake_wrap: assert property (@(posedge clk) disable iff (srst)
		wakePtr_reg <= mwj_pkg::WAKE_LAST)
		else $error("Pattern pointer out of range.");
endmodule

// ### bench/mwj_host_model.sv
// Host side model that issues single word register accesses.
module mwj_host_model (
	clk,
	rdata,
	csr
);
	timeunit 1ns;
	timeprecision 1ns;
	input  wire logic         clk;
	input  wire logic [31:0]  rdata;
	output mwj_pkg::mwj_csr_t csr;

	initial begin
		csr = '0;
	end

	task automatic write_reg(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		csr <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
		@(posedge clk);
		csr.wr    <= 1'b0;
		csr.wdata <= ~d;
	endtask

	task automatic read_reg(input logic [7:0] a, output logic [31:0] d);
		@(posedge clk);
		csr <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0000_0000};
		@(posedge clk);
		csr.rd <= 1'b0;
		@(posedge clk);
		d = rdata;
	endtask
endmodule

// ### bench/mwj_testbench.sv
// Self-checking testbench of the MAC supervision block.
module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	typedef struct {
		logic        wr;
		logic [7:0]  addr;
		logic [31:0] wdata;
		logic [31:0] exp;
	} mwj_row_t;
	logic                 clk = 1'b0;
	logic                 srst = 1'b1;
	mwj_pkg::mwj_csr_t    csr;
	mwj_pkg::mwj_link_t   link = '0;
	mwj_pkg::mwj_events_t events = '0;
	logic [31:0]          rdata;
	logic [31:0]          wakeWordData;
	logic [4:0]           wakeWordIndex;
	logic                 rxWatchdogExpired;
	logic                 txCutOff;
	logic                 wakeWordValid;
	int                   fail_count = 0;
	int                   total_checks = 0;
	int                   n;
	mwj_row_t             rows [6] = '{
		'{1'b0, 8'h78, 32'h0000_0000, 32'h0000_0000},
		'{1'b0, 8'h80, 32'h0000_0000, 32'h2000_0000},
		'{1'b0, 8'h84, 32'h0000_0000, 32'h0000_0000},
		'{1'b1, 8'h78, 32'hFFFF_FFFF, 32'h0000_0037},
		'{1'b1, 8'h84, 32'hFFFF_FFFF, 32'hF400_0000},
		'{1'b1, 8'h90, 32'hFFFF_FFFF, 32'h0000_0000}
	};

	always #50 clk = ~clk;

	// Link ticks every other cycle for the whole run.
	always @(posedge clk) begin
		link.txByte <= ~link.txByte;
		link.rxByte <= ~link.rxByte;
		link.rxBit  <= ~link.rxBit;
	end

	mwj_host_model host (
		.clk   (clk),
		.rdata (rdata),
		.csr   (csr)
	);

	mwj_top #(.HOLD_CYC_100(20), .HOLD_CYC_10(40), .JAB_CYC_100(10), .JAB_CYC_10(30)) DUT (
		.clk               (clk),
		.srst              (srst),
		.csr               (csr),
		.link              (link),
		.events            (events),
		.rdata             (rdata),
		.rxWatchdogExpired (rxWatchdogExpired),
		.txCutOff          (txCutOff),
		.wakeWordData      (wakeWordData),
		.wakeWordIndex     (wakeWordIndex),
		.wakeWordValid     (wakeWordValid)
	);

	task automatic finish_test();
		if (fail_count == 0 && total_checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
		total_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("wrong value %s expected %h seen %h", name, exp, got);
		end
	endtask

	task automatic chk_rng(input string name, input int c, input int lo, input int hi);
		total_checks++;
		if (c < lo || c > hi) begin
			fail_count++;
			$display("wrong value %s expected %0d..%0d seen %0d", name, lo, hi, c);
		end
	endtask

	task automatic rdchk(input string name, input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] d;
		host.read_reg(a, d);
		check(name, exp, d);
	endtask

	task automatic count_until(input logic rx, input logic lvl, output int c);
		c = 0;
		while ((rx ? rxWatchdogExpired : txCutOff) !== lvl && c < 9000) begin
			@(posedge clk);
			#1 c++;
		end
		if (c >= 9000) begin
			fail_count++;
			finish_test();
		end
	endtask

	task automatic pulse_events(input logic p);
		@(posedge clk);
		events.pauseEnable <= p;
		{events.txEarly, events.rxEarly, events.txDeferred, events.pauseRx} <= 4'hF;
		@(posedge clk);
		{events.txEarly, events.rxEarly, events.txDeferred, events.pauseRx} <= 4'h0;
	endtask

	initial begin
		repeat (5) @(posedge clk);
		srst <= 1'b0;
		foreach (rows[i]) begin
			if (rows[i].wr) host.write_reg(rows[i].addr, rows[i].wdata);
			rdchk("table", rows[i].addr, rows[i].exp);
		end
		for (int b = 0; b < 7; b++) begin
			host.write_reg(8'h80, 32'h2000_0000);
			@(posedge clk);
			events.xcvrIrq <= 7'(1 << b);
			@(posedge clk);
			events.xcvrIrq <= 7'h00;
			rdchk("xcvr", 8'h80, 32'h2000_0000);
		end
		host.write_reg(8'h80, 32'hFFFF_FFFF);
		host.write_reg(8'h84, 32'h0000_0000);
		pulse_events(1'b0);
		rdchk("gated", 8'h80, 32'h1000_0000);
		host.write_reg(8'h80, 32'hF400_0000);
		host.write_reg(8'h84, 32'hC000_0000);
		pulse_events(1'b1);
		rdchk("flags", 8'h80, 32'hD400_0000);
		rdchk("latch", 8'h80, 32'hD400_0000);
		host.write_reg(8'h80, 32'h8000_0000);
		rdchk("w1c31", 8'h80, 32'h5400_0000);
		host.write_reg(8'h80, 32'h4000_0000);
		rdchk("w1c30", 8'h80, 32'h1400_0000);
		host.write_reg(8'h80, 32'h1400_0000);
		for (int c = 0; c < 3; c++) begin
			events.fatalBusError <= 1'b1;
			events.busErrCode <= 3'(c);
			rdchk("errtype", 8'h80, 32'(c) << 23);
		end
		events.fatalBusError <= 1'b0;
		rdchk("errgate", 8'h80, 32'h0000_0000);
		for (int k = 0; k < 26; k++) begin
			host.write_reg(8'h70, 32'hA500_0000 + 32'(k));
			@(negedge clk);
			check("wakeidx", {26'h0, 1'b1, 5'(k % 25)}, {26'h0, wakeWordValid, wakeWordIndex});
			check("wakedata", 32'hA500_0000 + 32'(k), wakeWordData);
		end
		for (int s = 0; s < 2; s++) begin
			link.speed100 <= s[0];
			host.write_reg(8'h78, 32'h0000_0000);
			link.txActive <= 1'b1;
			count_until(1'b0, 1'b1, n);
			chk_rng("jabcut", n, s ? 10 : 30, s ? 13 : 33);
			link.txActive <= 1'b0;
			count_until(1'b0, 1'b0, n);
			chk_rng("holdoff", n, s ? 18 : 38, s ? 23 : 43);
		end
		host.write_reg(8'h78, 32'h0000_0006);
		link.txActive <= 1'b1;
		count_until(1'b0, 1'b1, n);
		chk_rng("jabbyte", n, 5115, 5130);
		count_until(1'b0, 1'b0, n);
		chk_rng("noholdoff", n, 0, 2);
		host.write_reg(8'h78, 32'h0000_0001);
		for (int t = 0; t < 60; t++) begin
			@(negedge clk);
			check("jabdis", 32'h0, {31'h0, txCutOff});
		end
		link.txActive <= 1'b0;
		for (int r = 0; r < 2; r++) begin
			host.write_reg(8'h78, r ? 32'h0000_0020 : 32'h0000_0000);
			link.carrier <= 1'b1;
			count_until(1'b1, 1'b1, n);
			chk_rng("rxwd", n, 5115, 5130);
			link.carrier <= 1'b0;
			count_until(1'b1, 1'b0, n);
			chk_rng("rxrel", n, r ? 92 : 44, r ? 100 : 52);
		end
		host.write_reg(8'h78, 32'h0000_0010);
		link.carrier <= 1'b1;
		repeat (5300) @(posedge clk);
		check("rxwddis", 32'h0, {31'h0, rxWatchdogExpired});
		finish_test();
	end
endmodule
